//--- logic/module_sideband_control.sv
`timescale 1ns/1ns

module module_sideband_control #(
   parameter int unsigned INIT_CYCLES = sideband_pkg::INIT_CYCLES
) (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [3:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_write,
   input  wire logic       i_reg_read,
   output logic      [7:0] o_reg_rdata,
   // Core events and interrupt
   input  wire logic       i_fault_event,
   output logic            o_irq,
   // Sideband pins
   input  wire logic       i_module_select_pin_n,
   input  wire logic       i_module_restart_n,
   input  wire logic       i_power_save_request,
   output logic            o_module_present_n,
   output logic            o_attention_n,
   output logic            o_attention_oe_n,
   // Management bus pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe_n,
   // Module state
   output logic            o_power_save,
   output logic            o_data_not_ready
);

   // ----------------------------------------
   // Read decoders
   // ----------------------------------------
   function automatic logic [7:0] mem_read(input logic [7:0] idx, input logic dnr,
                                           input logic [1:0] st, input logic [7:0] ctl);
      logic [7:0] val;
      val = 8'h00;
      case (idx)
         sideband_pkg::MEM_STATUS:  val = {7'h00, dnr};
         sideband_pkg::MEM_FLAGS:   val = {6'h00, st};
         sideband_pkg::MEM_CONTROL: val = ctl;
         default:                   val = 8'h00;
      endcase
      return val;
   endfunction

   function automatic logic [7:0] reg_read(input logic [3:0] adr, input logic [1:0] st,
                                           input logic [1:0] msk, input logic [7:0] ctl,
                                           input logic [3:0] state_bits);
      logic [7:0] val;
      val = 8'h00;
      case (adr)
         sideband_pkg::REG_STATUS:  val = {6'h00, st};
         sideband_pkg::REG_MASK:    val = {6'h00, msk};
         sideband_pkg::REG_CONTROL: val = ctl;
         sideband_pkg::REG_STATE:   val = {4'h0, state_bits};
         default:                   val = 8'h00;
      endcase
      return val;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic       scl_prev;
   logic       sda_prev;
   logic       restart_prev;
   logic [4:0] pins_in;

   assign pins_in = {i_sda, i_scl, i_power_save_request, i_module_restart_n, i_module_select_pin_n};

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sync1        <= sideband_pkg::SYNC_RESET;
         sync2        <= sideband_pkg::SYNC_RESET;
         scl_prev     <= 1'b1;
         sda_prev     <= 1'b1;
         restart_prev <= 1'b1;
      end else begin
         sync1        <= pins_in;
         sync2        <= sync1;
         scl_prev     <= sync2[sideband_pkg::SY_SCL];
         sda_prev     <= sync2[sideband_pkg::SY_SDA];
         restart_prev <= sync2[sideband_pkg::SY_RESTART];
      end
   end

   logic selected;
   logic restart_s;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign selected   = ~sync2[sideband_pkg::SY_SEL];
   assign restart_s  = sync2[sideband_pkg::SY_RESTART];
   assign scl_s      = sync2[sideband_pkg::SY_SCL];
   assign sda_s      = sync2[sideband_pkg::SY_SDA];
   assign scl_rise   = scl_s & ~scl_prev;
   assign scl_fall   = ~scl_s & scl_prev;
   assign start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s;

   // ----------------------------------------
   // Restart qualification and completion
   // ----------------------------------------
   logic [sideband_pkg::LOW_CNT_W-1:0]  low_cnt;
   logic [sideband_pkg::LOW_CNT_W-1:0]  next_low_cnt;
   logic [sideband_pkg::INIT_CNT_W-1:0] init_cnt;
   logic [sideband_pkg::INIT_CNT_W-1:0] next_init_cnt;
   logic                                not_ready;
   logic                                next_not_ready;
   logic                                qualified;
   logic                                done_evt;

   assign qualified = ~restart_s & (low_cnt == sideband_pkg::LOW_CNT_W'(sideband_pkg::RESTART_MIN_CYCLES));

   always_comb begin
      next_low_cnt   = '0;
      next_init_cnt  = init_cnt;
      next_not_ready = not_ready;
      done_evt       = 1'b0;
      if (!restart_s && !qualified) begin
         next_low_cnt = low_cnt + 1'b1;
      end else if (!restart_s) begin
         next_low_cnt = low_cnt;
      end
      if (qualified) begin
         next_init_cnt  = sideband_pkg::INIT_CNT_W'(INIT_CYCLES);
         next_not_ready = 1'b1;
      end else if (init_cnt != '0) begin
         next_init_cnt = init_cnt - 1'b1;
         if (init_cnt == sideband_pkg::INIT_CNT_W'(1)) begin
            next_not_ready = 1'b0;
            done_evt       = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         low_cnt   <= '0;
         init_cnt  <= sideband_pkg::INIT_CNT_W'(INIT_CYCLES);
         not_ready <= 1'b1;
      end else begin
         low_cnt   <= next_low_cnt;
         init_cnt  <= next_init_cnt;
         not_ready <= next_not_ready;
      end
   end

   // ----------------------------------------
   // Two-wire management slave
   // ----------------------------------------
   sideband_pkg::tw_state_t tw_state;
   sideband_pkg::tw_state_t next_tw_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] ptr;
   logic [7:0] next_ptr;
   logic       drive_low;
   logic       next_drive_low;
   logic       first_byte;
   logic       next_first_byte;
   logic       ack_ok;
   logic       next_ack_ok;
   logic       tw_write;
   logic [1:0] status;
   logic [7:0] control;
   logic [7:0] load_byte;

   assign load_byte = mem_read(ptr, not_ready, status, control);

   always_comb begin
      next_tw_state   = tw_state;
      next_bit_cnt    = bit_cnt;
      next_shift      = shift;
      next_ptr        = ptr;
      next_drive_low  = drive_low;
      next_first_byte = first_byte;
      next_ack_ok     = ack_ok;
      tw_write        = 1'b0;
      if (!selected) begin
         next_tw_state  = sideband_pkg::TW_IDLE;
         next_drive_low = 1'b0;
      end else if (start_cond) begin
         next_tw_state  = sideband_pkg::TW_ADDR;
         next_bit_cnt   = 4'h0;
         next_drive_low = 1'b0;
      end else if (stop_cond) begin
         next_tw_state  = sideband_pkg::TW_IDLE;
         next_drive_low = 1'b0;
      end else begin
         case (tw_state)
            sideband_pkg::TW_ADDR, sideband_pkg::TW_WR_BYTE: begin
               if (scl_rise && bit_cnt != sideband_pkg::BITS_IN_BYTE) begin
                  next_shift   = {shift[6:0], sda_s};
                  next_bit_cnt = bit_cnt + 1'b1;
               end else if (scl_fall && bit_cnt == sideband_pkg::BITS_IN_BYTE) begin
                  if (tw_state == sideband_pkg::TW_WR_BYTE) begin
                     next_tw_state   = sideband_pkg::TW_WR_ACK;
                     next_drive_low  = 1'b1;
                     next_first_byte = 1'b0;
                     if (first_byte) begin
                        next_ptr = shift;
                     end else begin
                        tw_write = 1'b1;
                        next_ptr = ptr + 1'b1;
                     end
                  end else if (shift[7:1] == sideband_pkg::DEV_ADDR) begin
                     next_tw_state  = sideband_pkg::TW_ADDR_ACK;
                     next_drive_low = 1'b1;
                  end else begin
                     next_tw_state = sideband_pkg::TW_IDLE;
                  end
               end
            end
            sideband_pkg::TW_ADDR_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (shift[0]) begin
                     next_tw_state  = sideband_pkg::TW_RD_BYTE;
                     next_shift     = load_byte;
                     next_ptr       = ptr + 1'b1;
                     next_drive_low = ~load_byte[7];
                  end else begin
                     next_tw_state   = sideband_pkg::TW_WR_BYTE;
                     next_drive_low  = 1'b0;
                     next_first_byte = 1'b1;
                  end
               end
            end
            sideband_pkg::TW_WR_ACK: begin
               if (scl_fall) begin
                  next_tw_state  = sideband_pkg::TW_WR_BYTE;
                  next_bit_cnt   = 4'h0;
                  next_drive_low = 1'b0;
               end
            end
            sideband_pkg::TW_RD_BYTE: begin
               if (scl_fall && bit_cnt == sideband_pkg::LAST_BIT) begin
                  next_tw_state  = sideband_pkg::TW_RD_ACK;
                  next_drive_low = 1'b0;
               end else if (scl_fall) begin
                  next_shift     = {shift[6:0], 1'b0};
                  next_bit_cnt   = bit_cnt + 1'b1;
                  next_drive_low = ~shift[6];
               end
            end
            sideband_pkg::TW_RD_ACK: begin
               if (scl_rise) begin
                  next_ack_ok = ~sda_s;
               end else if (scl_fall && ack_ok) begin
                  next_tw_state  = sideband_pkg::TW_RD_BYTE;
                  next_bit_cnt   = 4'h0;
                  next_shift     = load_byte;
                  next_ptr       = ptr + 1'b1;
                  next_drive_low = ~load_byte[7];
               end else if (scl_fall) begin
                  next_tw_state = sideband_pkg::TW_IDLE;
               end
            end
            default: begin
               next_tw_state  = sideband_pkg::TW_IDLE;
               next_drive_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tw_state   <= sideband_pkg::TW_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         ptr        <= 8'h00;
         drive_low  <= 1'b0;
         first_byte <= 1'b0;
         ack_ok     <= 1'b0;
      end else begin
         tw_state   <= next_tw_state;
         bit_cnt    <= next_bit_cnt;
         shift      <= next_shift;
         ptr        <= next_ptr;
         drive_low  <= next_drive_low;
         first_byte <= next_first_byte;
         ack_ok     <= next_ack_ok;
      end
   end

   // ----------------------------------------
   // Status, mask, control and pin outputs
   // ----------------------------------------
   logic [1:0] mask;
   logic [1:0] next_status;
   logic [1:0] next_mask;
   logic [7:0] next_control;
   logic [7:0] next_rdata;
   logic       next_power_save;
   logic       next_irq;
   logic [1:0] events;
   logic [1:0] clear_bits;
   logic       restarting;

   assign restarting = init_cnt != '0;

   always_comb begin
      events                               = 2'h0;
      events[sideband_pkg::ST_RESTART_DONE] = done_evt;
      events[sideband_pkg::ST_FAULT]        = i_fault_event;
      clear_bits   = 2'h0;
      next_mask    = mask;
      next_control = control;
      if (i_reg_write && i_reg_addr == sideband_pkg::REG_STATUS) begin
         clear_bits = i_reg_wdata[1:0];
      end
      if (i_reg_write && i_reg_addr == sideband_pkg::REG_MASK) begin
         next_mask = i_reg_wdata[1:0];
      end
      if (i_reg_write && i_reg_addr == sideband_pkg::REG_CONTROL) begin
         next_control = i_reg_wdata;
      end
      if (tw_write && ptr == sideband_pkg::MEM_CONTROL) begin
         next_control = shift;
      end
      next_status = (status & ~clear_bits) | events;
      if (qualified) begin
         next_status  = events;
         next_mask    = sideband_pkg::MASK_RESET;
         next_control = sideband_pkg::CONTROL_RESET;
      end
      next_rdata = 8'h00;
      if (i_reg_read) begin
         next_rdata = reg_read(i_reg_addr, status, mask, control,
                               {restarting, selected, o_power_save, not_ready});
      end
      next_irq        = |(next_status & next_mask);
      next_power_save = sync2[sideband_pkg::SY_LP] | next_control[sideband_pkg::CTRL_POWER_SAVE];
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         status             <= 2'h0;
         mask               <= sideband_pkg::MASK_RESET;
         control            <= sideband_pkg::CONTROL_RESET;
         o_reg_rdata        <= 8'h00;
         o_irq              <= 1'b0;
         o_attention_oe_n   <= 1'b1;
         o_power_save       <= 1'b0;
      end else begin
         status             <= next_status;
         mask               <= next_mask;
         control            <= next_control;
         o_reg_rdata        <= next_rdata;
         o_irq              <= next_irq;
         o_attention_oe_n   <= ~next_irq;
         o_power_save       <= next_power_save;
      end
   end

   always_ff @(posedge i_core_clk) begin
      o_module_present_n <= 1'b0;
      o_attention_n      <= 1'b0;
      o_sda              <= 1'b0;
      o_sda_oe_n         <= ~next_drive_low;
      o_data_not_ready   <= next_not_ready;
   end

endmodule

//--- logic/sideband_pkg.sv
package sideband_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CORE_CLK_HZ        = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS      = 40;
   localparam int unsigned RESTART_MIN_NS     = 10_000;
   localparam int unsigned RESTART_MIN_CYCLES = (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_TIME_MS       = 2000;
   localparam int unsigned INIT_CYCLES        = INIT_TIME_MS * (CORE_CLK_HZ / 1000);
   localparam int unsigned LOW_CNT_W          = 8;
   localparam int unsigned INIT_CNT_W         = 26;

   // ----------------------------------------
   // Pin synchroniser lanes and reset levels
   // ----------------------------------------
   localparam int unsigned SY_SEL      = 0;
   localparam int unsigned SY_RESTART  = 1;
   localparam int unsigned SY_LP       = 2;
   localparam int unsigned SY_SCL      = 3;
   localparam int unsigned SY_SDA      = 4;
   localparam logic [4:0]  SYNC_RESET  = 5'h1b;

   // ----------------------------------------
   // Register port map
   // ----------------------------------------
   localparam logic [3:0] REG_STATUS  = 4'h0;
   localparam logic [3:0] REG_MASK    = 4'h1;
   localparam logic [3:0] REG_CONTROL = 4'h2;
   localparam logic [3:0] REG_STATE   = 4'h3;

   localparam int unsigned STATUS_W        = 2;
   localparam int unsigned ST_RESTART_DONE = 0;
   localparam int unsigned ST_FAULT        = 1;
   localparam logic [1:0]  MASK_RESET      = 2'h3;
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam int unsigned CTRL_POWER_SAVE = 0;

   // ----------------------------------------
   // Management bus map
   // ----------------------------------------
   localparam logic [6:0] DEV_ADDR     = 7'h50;
   localparam logic [7:0] MEM_STATUS   = 8'h02;
   localparam logic [7:0] MEM_FLAGS    = 8'h03;
   localparam logic [7:0] MEM_CONTROL  = 8'h56;
   localparam logic [3:0] BITS_IN_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT     = 4'h7;

   typedef enum logic [2:0] {
      TW_IDLE     = 3'h0,
      TW_ADDR     = 3'h1,
      TW_ADDR_ACK = 3'h3,
      TW_WR_BYTE  = 3'h2,
      TW_WR_ACK   = 3'h6,
      TW_RD_BYTE  = 3'h7,
      TW_RD_ACK   = 3'h5
   } tw_state_t;

endpackage

//--- tb/module_sideband_control_bench.sv
`timescale 1ns/1ns

module module_sideband_control_bench;
   localparam int unsigned INIT = 20;
   logic       i_core_clk;
   logic       i_rst;
   logic [3:0] i_reg_addr;
   logic [7:0] i_reg_wdata;
   logic       i_reg_write;
   logic       i_reg_read;
   logic [7:0] o_reg_rdata;
   logic       i_fault_event;
   logic       o_irq;
   logic       i_module_select_pin_n;
   logic       i_module_restart_n;
   logic       i_power_save_request;
   logic       o_module_present_n;
   logic       o_attention_n;
   logic       o_attention_oe_n;
   logic       i_scl;
   wire        i_sda;
   logic       o_sda;
   logic       o_sda_oe_n;
   logic       o_power_save;
   logic       o_data_not_ready;
   int         miscompares;
   int         num_checks;

   module_sideband_control #(.INIT_CYCLES(INIT)) uut (.*);
   tw_host_model host (.i_sda_oe_n(o_sda_oe_n), .o_scl(i_scl), .o_sda(i_sda));

   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end

   function automatic logic exp_irq(input logic [1:0] st, input logic [1:0] m);
      return |(st & m);
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_write <= 1'b1;
      @(posedge i_core_clk);
      i_reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_read <= 1'b1;
      @(posedge i_core_clk);
      i_reg_read <= 1'b0;
      #1 q = o_reg_rdata;
   endtask

   task automatic wait_ready(output int n);
      n = 0;
      while (o_data_not_ready !== 1'b0 && n < 400) begin
         @(posedge i_core_clk);
         #1 n++;
      end
   endtask

   task automatic final_report();
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge i_core_clk);
      miscompares++;
      final_report();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] q;
      logic [7:0] d;
      logic [1:0] m;
      logic       ok;
      int         n;
      void'($urandom(32'hed18bca6));
      {i_rst, i_reg_addr, i_reg_wdata, i_reg_write, i_reg_read} = {1'b1, 4'h0, 8'h00, 2'h0};
      {i_fault_event, i_module_select_pin_n, i_module_restart_n, i_power_save_request} = 4'h6;
      repeat (10) @(posedge i_core_clk);
      i_rst <= 1'b0;
      wait_ready(n);
      check("power-up ready in time", 8'(n >= INIT && n < 400), 8'h01);
      check("attention after power-up", 8'(o_attention_oe_n), 8'h00);
      reg_rd(sideband_pkg::REG_STATUS, q);
      check("status after power-up", q, 8'h01);
      reg_rd(sideband_pkg::REG_MASK, q);
      check("mask reset", q, 8'h03);
      reg_rd(sideband_pkg::REG_STATE, q);
      check("state reset", q, 8'h00);
      reg_wr(sideband_pkg::REG_STATUS, 8'h01);
      reg_rd(sideband_pkg::REG_STATUS, q);
      check("status cleared", q, 8'h00);
      for (int k = 0; k < 4; k++) begin
         m = 2'($urandom());
         reg_wr(sideband_pkg::REG_MASK, {6'h00, m});
         @(posedge i_core_clk);
         i_fault_event <= 1'b1;
         @(posedge i_core_clk);
         i_fault_event <= 1'b0;
         repeat (2) @(posedge i_core_clk);
         #1 check("irq on fault", 8'(o_irq), 8'(exp_irq(2'h2, m)));
         reg_wr(sideband_pkg::REG_STATUS, 8'hff);
         reg_rd(sideband_pkg::REG_STATUS, q);
         check("status after clear", q, 8'h00);
      end
      @(posedge i_core_clk);
      {i_fault_event, i_reg_write, i_reg_addr, i_reg_wdata} <= {2'h3, sideband_pkg::REG_STATUS, 8'h02};
      @(posedge i_core_clk);
      {i_fault_event, i_reg_write} <= 2'h0;
      reg_rd(sideband_pkg::REG_STATUS, q);
      check("set beats clear", q, 8'h02);
      d = 8'($urandom());
      reg_wr(4'h4 + 4'($urandom_range(11)), d);
      reg_rd(4'h4 + 4'($urandom_range(11)), q);
      check("unmapped read", q, 8'h00);
      i_module_select_pin_n <= 1'b0;
      host.access(1'b0, sideband_pkg::MEM_CONTROL, d, q, ok);
      check("bus write ack", 8'(ok), 8'h01);
      host.access(1'b1, sideband_pkg::MEM_CONTROL, 8'h00, q, ok);
      check("bus read back", q, d);
      check("power save by control", 8'(o_power_save), 8'(d[0]));
      reg_wr(sideband_pkg::REG_CONTROL, 8'h00);
      i_power_save_request <= 1'b1;
      reg_rd(sideband_pkg::REG_STATE, q);
      reg_rd(sideband_pkg::REG_STATE, q);
      check("state selected and saving", q, 8'h06);
      i_power_save_request <= 1'b0;
      i_module_select_pin_n <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      host.access(1'b0, sideband_pkg::MEM_CONTROL, 8'h01, q, ok);
      check("deselected ack", 8'(ok), 8'h00);
      reg_rd(sideband_pkg::REG_CONTROL, q);
      check("deselected write ignored", q, 8'h00);
      @(posedge i_core_clk);
      i_module_restart_n <= 1'b0;
      repeat (100) @(posedge i_core_clk);
      i_module_restart_n <= 1'b1;
      repeat (10) @(posedge i_core_clk);
      #1 check("short restart ignored", 8'(o_data_not_ready), 8'h00);
      reg_wr(sideband_pkg::REG_CONTROL, 8'h5a);
      reg_wr(sideband_pkg::REG_MASK, 8'h00);
      i_module_restart_n <= 1'b0;
      repeat (300) @(posedge i_core_clk);
      #1 check("restart busy", 8'(o_data_not_ready), 8'h01);
      reg_rd(sideband_pkg::REG_CONTROL, q);
      check("control default", q, 8'h00);
      reg_rd(sideband_pkg::REG_MASK, q);
      check("mask default", q, 8'h03);
      @(posedge i_core_clk);
      i_module_restart_n <= 1'b1;
      wait_ready(n);
      check("init span", 8'(n >= INIT && n < 400), 8'h01);
      check("attention on completion", 8'(o_attention_oe_n), 8'h00);
      i_module_select_pin_n <= 1'b0;
      host.access(1'b1, sideband_pkg::MEM_FLAGS, 8'h00, q, ok);
      check("flags after attention", q, 8'h01);
      host.access(1'b1, sideband_pkg::MEM_STATUS, 8'h00, q, ok);
      check("not ready cleared", q, 8'h00);
      final_report();
   end
endmodule

//--- tb/sideband_assertions.sv
`timescale 1ns/1ns

module sideband_checker #(
   parameter int unsigned INIT_CYCLES = 20
) (
   // Watched ports
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       i_reg_read,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_irq,
   input wire logic       i_module_select_pin_n,
   input wire logic       i_module_restart_n,
   input wire logic       i_power_save_request,
   input wire logic       o_module_present_n,
   input wire logic       o_attention_n,
   input wire logic       o_attention_oe_n,
   input wire logic       o_sda,
   input wire logic       o_sda_oe_n,
   input wire logic       o_power_save,
   input wire logic       o_data_not_ready
);
   logic [8:0] low_cnt;
   logic [8:0] next_low_cnt;
   logic [7:0] busy_cnt;
   logic [7:0] next_busy_cnt;
   logic       pin_q;

   // ----------------------------------------
   // Restart low time and span since release
   // ----------------------------------------
   always_comb begin
      next_low_cnt = i_module_restart_n ? 9'h000 : low_cnt + 9'((low_cnt != 9'h1ff) ? 1 : 0);
      next_busy_cnt = (!pin_q && i_module_restart_n) ? 8'h00 : busy_cnt + 8'((busy_cnt != 8'hff) ? 1 : 0);
   end

   always_ff @(posedge i_core_clk) begin
      low_cnt  <= i_rst ? 9'h000 : next_low_cnt;
      busy_cnt <= i_rst ? 8'h00 : next_busy_cnt;
      pin_q    <= i_module_restart_n;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_release;
      o_data_not_ready && $rose(i_module_restart_n);
   endsequence
   sequence s_ready;
      ##[1:60] $fell(o_data_not_ready) ##0 o_irq;
   endsequence

   a_present_low: assert property (o_module_present_n == 1'b0)
      else $error("presence not low");
   a_attn_open_drain: assert property (o_attention_n == 1'b0 && o_attention_oe_n == !o_irq)
      else $error("attention not open drain or not tied to irq");
   a_deselect_quiet: assert property (i_module_select_pin_n [*4] |-> o_sda_oe_n && o_sda == 1'b0)
      else $error("data line driven while deselected");
   a_power_save_pin: assert property (i_power_save_request [*4] |-> o_power_save)
      else $error("power save not entered");
   a_rdata_idle: assert property (!i_reg_read |=> o_reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_restart_busy: assert property (low_cnt > 9'd255 |-> o_data_not_ready)
      else $error("long restart low not taken");
   a_init_span: assert property ($fell(o_data_not_ready) |-> busy_cnt >= 8'(INIT_CYCLES - 2))
      else $error("ready too early");
   a_ready_irq: assert property ($fell(o_data_not_ready) |-> o_irq && !o_attention_oe_n)
      else $error("ready without attention");
   a_restart_done: assert property (s_release |-> s_ready)
      else $error("restart did not complete");
endmodule

bind module_sideband_control sideband_checker #(.INIT_CYCLES(INIT_CYCLES)) chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
   .o_irq(o_irq), .i_module_select_pin_n(i_module_select_pin_n), .i_module_restart_n(i_module_restart_n),
   .i_power_save_request(i_power_save_request), .o_module_present_n(o_module_present_n),
   .o_attention_n(o_attention_n), .o_attention_oe_n(o_attention_oe_n), .o_sda(o_sda),
   .o_sda_oe_n(o_sda_oe_n), .o_power_save(o_power_save), .o_data_not_ready(o_data_not_ready));

//--- tb/tw_host_model.sv
`timescale 1ns/1ns

module tw_host_model (
   // Device side
   input  wire logic i_sda_oe_n,
   // Bus lines
   output logic      o_scl,
   output wire logic o_sda
);
   logic pull_low;

   assign o_sda = !(pull_low || !i_sda_oe_n);

   initial begin
      o_scl    = 1'b1;
      pull_low = 1'b0;
   end

   task automatic bit_io(input logic b, output logic r);
      pull_low = !b;
      #80 o_scl = 1'b1;
      #80 r = o_sda;
      #80 o_scl = 1'b0;
      #80;
   endtask

   task automatic start_cond();
      pull_low = 1'b0;
      #80 o_scl = 1'b1;
      #80 pull_low = 1'b1;
      #80 o_scl = 1'b0;
      #80;
   endtask

   task automatic send_byte(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ok = ok && !r;
   endtask

   // ----------------------------------------
   // Pointer write, then one data byte out or in
   // ----------------------------------------
   task automatic access(input logic rd, input logic [7:0] ptr, input logic [7:0] wd,
                         output logic [7:0] q, output logic ok);
      logic r;
      ok = 1'b1;
      q  = 8'h00;
      #13;
      start_cond();
      send_byte({sideband_pkg::DEV_ADDR, 1'b0}, ok);
      send_byte(ptr, ok);
      if (rd) begin
         start_cond();
         send_byte({sideband_pkg::DEV_ADDR, 1'b1}, ok);
         for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            q[i] = r;
         end
         bit_io(1'b1, r);
      end else begin
         send_byte(wd, ok);
      end
      pull_low = 1'b1;
      #80 o_scl = 1'b1;
      #80 pull_low = 1'b0;
      #80;
   endtask
endmodule
